/* include/pmc_pkg.sv */
package pmc_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_POWER_MODE_COMMAND = 8'h87;
    localparam logic [7:0] ADDR_SLEEP_CTRL = 8'hbe;
    localparam logic [7:0] ADDR_CLOCK_CONTROL_REG = 8'hc6;

    // Command register fields
    localparam int CMD_ENTER_BIT = 0;
    localparam logic [5:0] CMD_SPARE_RESET = 6'h00;

    // Sleep control fields
    localparam int SLP_CRYSTAL_STABLE_FLAG_BIT = 6;
    localparam int SLP_HFRC_STB_BIT = 5;
    localparam int SLP_RST_LSB = 3;
    localparam int SLP_UNUSED_OSC_POWERDOWN_BIT = 2;
    localparam int SLP_MODE_LSB = 0;
    localparam logic SLP_UNUSED_OSC_POWERDOWN_RESET = 1'b1;
    localparam logic [1:0] SLP_MODE_RESET = 2'h0;
    localparam logic [1:0] RST_CAUSE_POR = 2'h0;

    // Clock control fields
    localparam int CLK_LOWFREQ_SOURCE_SELECT_BIT = 7;
    localparam int CLK_OSC_BIT = 6;
    localparam int CLK_TICK_LSB = 3;
    localparam int CLK_RSVD_LSB = 1;
    localparam int CLK_SPD_BIT = 0;
    localparam logic CLK_LOWFREQ_SOURCE_SELECT_RESET = 1'b1;
    localparam logic CLK_OSC_RESET = 1'b1;
    localparam logic [2:0] CLK_TICK_RESET = 3'h1;
    localparam logic [1:0] CLK_RSVD_RESET = 2'h0;
    localparam logic CLK_SPD_RESET = 1'b1;

    // Power mode encodings
    localparam logic [1:0] MODE_FULL_RUN = 2'h0;
    localparam logic [1:0] MODE_SHORT_SLEEP = 2'h1;
    localparam logic [1:0] MODE_LONG_SLEEP = 2'h2;
    localparam logic [1:0] MODE_DEEPEST_SLEEP = 2'h3;

    // Sequencing times
    localparam int CLK_SYS_MHZ = 250;
    localparam int PD_SEQ_NS = 100;
    localparam int PD_SEQ_CYC = (PD_SEQ_NS * CLK_SYS_MHZ + 999) / 1000;
    localparam int CAL_NS = 1000;
    localparam int CAL_CYC = (CAL_NS * CLK_SYS_MHZ + 999) / 1000;
    localparam logic [7:0] PD_SEQ_CYC_W = 8'(PD_SEQ_CYC);
    localparam logic [7:0] CAL_CYC_W = 8'(CAL_CYC);

    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_PWRDN = 6'h02,
        ST_SLEEP = 6'h04,
        ST_REG_UP = 6'h08,
        ST_OSC_UP = 6'h10,
        ST_RELEASE = 6'h20
    } pmc_state_t;

    // Special function register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmc_sfr_req_t;

    // Power and clock enables toward the analog domain
    typedef struct packed {
        logic dig_reg_on;
        logic hs_crystal_osc_on;
        logic hfrc_on;
        logic lf_osc_on;
        logic lf_hs_crystal_osc_sel;
        logic core_clk_on;
        logic periph_on;
        logic io_hold;
        logic volatile_ram_on;
        logic radio_buf_on;
        logic retained_on;
    } pmc_pwr_ctrl_t;

    // Oscillator and regulator ready levels
    typedef struct packed {
        logic dig_reg_ok;
        logic hs_crystal_osc_ok;
        logic hfrc_ok;
    } pmc_ready_t;
endpackage : pmc_pkg

/* src/pmc_power_mode_ctrl.sv */
`timescale 1ns/10ps
module pmc_power_mode_ctrl (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire pmc_pkg::pmc_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic port_irq,
    input wire logic sleep_timer_evt,
    input wire logic por_event,
    input wire pmc_pkg::pmc_ready_t osc_ready,
    output pmc_pkg::pmc_pwr_ctrl_t pwr_ctrl,
    output logic sysclk_on_hs_crystal_osc,
    output logic timer_tick_en,
    output logic [1:0] power_mode
);
    // ==========================================================
    // Register decode
    logic wr_cmd;
    logic wr_slp;
    logic wr_clk;
    logic wake;
    assign wr_cmd = sfr_req.wr && sfr_req.addr == pmc_pkg::ADDR_POWER_MODE_COMMAND;
    assign wr_slp = sfr_req.wr && sfr_req.addr == pmc_pkg::ADDR_SLEEP_CTRL;
    assign wr_clk = sfr_req.wr && sfr_req.addr == pmc_pkg::ADDR_CLOCK_CONTROL_REG;

    pmc_pkg::pmc_state_t state_q;
    logic [1:0] mode_q;
    logic [1:0] active_mode_q;
    logic [5:0] cmd_spare_q;
    logic unused_osc_powerdown_q;
    logic unused_osc_powerdown_pend_q;
    logic osc_sel_q;
    logic osc_eff_q;
    logic lowfreq_source_select_q;
    logic [2:0] tick_q;
    logic [1:0] rsvd_q;
    logic spd_q;
    logic [7:0] seq_cnt_q;
    logic [7:0] cal_cnt_q;
    logic [6:0] tick_cnt_q;
    logic calibrating;
    logic hs_crystal_osc_running;

    // Wake sources; deepest sleep ignores the sleep timer
    assign wake = port_irq || por_event || (sleep_timer_evt && active_mode_q != pmc_pkg::MODE_DEEPEST_SLEEP);

    // ==========================================================
    // Command register spare bits
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cmd_spare_q <= pmc_pkg::CMD_SPARE_RESET;
        end else if (wr_cmd) begin
            cmd_spare_q <= sfr_req.wdata[7:2];
        end
    end

    // ==========================================================
    // Sleep mode field
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            mode_q <= pmc_pkg::SLP_MODE_RESET;
        end else if (wake && state_q != pmc_pkg::ST_RUN) begin
            mode_q <= pmc_pkg::MODE_FULL_RUN;
        end else if (wr_slp) begin
            mode_q <= sfr_req.wdata[pmc_pkg::SLP_MODE_LSB +: 2];
        end
    end

    // ==========================================================
    // Power mode sequencer
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= pmc_pkg::ST_RUN;
            active_mode_q <= pmc_pkg::MODE_FULL_RUN;
            seq_cnt_q <= 8'h00;
        end else begin
            case (state_q)
                pmc_pkg::ST_RUN: begin
                    // Command bit is a strobe, never stored
                    if (wr_cmd && sfr_req.wdata[pmc_pkg::CMD_ENTER_BIT] && mode_q != pmc_pkg::MODE_FULL_RUN) begin
                        state_q <= pmc_pkg::ST_PWRDN;
                        active_mode_q <= mode_q;
                        seq_cnt_q <= (mode_q == pmc_pkg::MODE_SHORT_SLEEP) ? 8'h01 : pmc_pkg::PD_SEQ_CYC_W;
                    end
                end
                pmc_pkg::ST_PWRDN: begin
                    if (seq_cnt_q <= 8'h01) begin
                        state_q <= pmc_pkg::ST_SLEEP;
                    end else begin
                        seq_cnt_q <= seq_cnt_q - 8'h01;
                    end
                end
                pmc_pkg::ST_SLEEP: begin
                    if (wake) begin
                        state_q <= pmc_pkg::ST_REG_UP;
                    end
                end
                pmc_pkg::ST_REG_UP: begin
                    if (osc_ready.dig_reg_ok) begin
                        state_q <= pmc_pkg::ST_OSC_UP;
                    end
                end
                pmc_pkg::ST_OSC_UP: begin
                    // Always restart on the RC; crystal is switched in later
                    if (osc_ready.hfrc_ok) begin
                        state_q <= pmc_pkg::ST_RELEASE;
                    end
                end
                pmc_pkg::ST_RELEASE: begin
                    state_q <= pmc_pkg::ST_RUN;
                    active_mode_q <= pmc_pkg::MODE_FULL_RUN;
                end
                default: begin
                    state_q <= pmc_pkg::ST_RUN;
                    active_mode_q <= pmc_pkg::MODE_FULL_RUN;
                end
            endcase
        end
    end

    // ==========================================================
    // Clock source selection
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            osc_sel_q <= pmc_pkg::CLK_OSC_RESET;
            lowfreq_source_select_q <= pmc_pkg::CLK_LOWFREQ_SOURCE_SELECT_RESET;
            tick_q <= pmc_pkg::CLK_TICK_RESET;
            rsvd_q <= pmc_pkg::CLK_RSVD_RESET;
            spd_q <= pmc_pkg::CLK_SPD_RESET;
        end else if (wr_clk) begin
            osc_sel_q <= sfr_req.wdata[pmc_pkg::CLK_OSC_BIT];
            tick_q <= sfr_req.wdata[pmc_pkg::CLK_TICK_LSB +: 3];
            rsvd_q <= sfr_req.wdata[pmc_pkg::CLK_RSVD_LSB +: 2];
            spd_q <= sfr_req.wdata[pmc_pkg::CLK_SPD_BIT];
            if (!hs_crystal_osc_running) begin
                lowfreq_source_select_q <= sfr_req.wdata[pmc_pkg::CLK_LOWFREQ_SOURCE_SELECT_BIT];
            end
        end
    end

    // Effective source follows the select only when the target is stable
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            osc_eff_q <= pmc_pkg::CLK_OSC_RESET;
        end else if (state_q == pmc_pkg::ST_OSC_UP) begin
            osc_eff_q <= 1'b1;
        end else if (state_q == pmc_pkg::ST_RUN && osc_eff_q != osc_sel_q) begin
            if (osc_sel_q ? osc_ready.hfrc_ok : osc_ready.hs_crystal_osc_ok) begin
                osc_eff_q <= osc_sel_q;
            end
        end
    end

    // ==========================================================
    // Oscillator power-down bit and low-frequency calibration
    assign calibrating = cal_cnt_q != 8'h00;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cal_cnt_q <= 8'h00;
        end else if (!hs_crystal_osc_running || lowfreq_source_select_q == 1'b0) begin
            cal_cnt_q <= 8'h00;
        end else if (calibrating) begin
            cal_cnt_q <= cal_cnt_q - 8'h01;
        end else if (osc_ready.hs_crystal_osc_ok && tick_cnt_q == 7'h00) begin
            cal_cnt_q <= pmc_pkg::CAL_CYC_W;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            unused_osc_powerdown_q <= pmc_pkg::SLP_UNUSED_OSC_POWERDOWN_RESET;
            unused_osc_powerdown_pend_q <= 1'b0;
        end else if (wr_clk && sfr_req.wdata[pmc_pkg::CLK_OSC_BIT] != osc_sel_q) begin
            unused_osc_powerdown_q <= 1'b0;
            unused_osc_powerdown_pend_q <= 1'b0;
        end else if (wr_slp) begin
            if (sfr_req.wdata[pmc_pkg::SLP_UNUSED_OSC_POWERDOWN_BIT] && calibrating) begin
                unused_osc_powerdown_pend_q <= 1'b1;
            end else begin
                unused_osc_powerdown_q <= sfr_req.wdata[pmc_pkg::SLP_UNUSED_OSC_POWERDOWN_BIT];
                unused_osc_powerdown_pend_q <= 1'b0;
            end
        end else if (unused_osc_powerdown_pend_q && !calibrating) begin
            unused_osc_powerdown_q <= 1'b1;
            unused_osc_powerdown_pend_q <= 1'b0;
        end
    end

    // ==========================================================
    // Power and clock enables
    logic running;
    logic deep;
    assign running = state_q == pmc_pkg::ST_RUN || state_q == pmc_pkg::ST_RELEASE;
    assign deep = !running && state_q != pmc_pkg::ST_PWRDN && active_mode_q[1];
    assign hs_crystal_osc_running = pwr_ctrl.hs_crystal_osc_on;

    always_comb begin
        pwr_ctrl.dig_reg_on = !(state_q == pmc_pkg::ST_SLEEP && active_mode_q[1]);
        pwr_ctrl.hs_crystal_osc_on = running && (!unused_osc_powerdown_q || !osc_sel_q || !osc_eff_q);
        pwr_ctrl.hfrc_on = (running && (!unused_osc_powerdown_q || osc_sel_q || osc_eff_q)) ||
            state_q == pmc_pkg::ST_OSC_UP;
        pwr_ctrl.lf_osc_on = active_mode_q != pmc_pkg::MODE_DEEPEST_SLEEP || running;
        pwr_ctrl.lf_hs_crystal_osc_sel = !lowfreq_source_select_q;
        pwr_ctrl.core_clk_on = running;
        pwr_ctrl.periph_on = running || state_q == pmc_pkg::ST_PWRDN;
        pwr_ctrl.io_hold = deep;
        pwr_ctrl.volatile_ram_on = !deep;
        pwr_ctrl.radio_buf_on = !deep;
        pwr_ctrl.retained_on = 1'b1;
    end

    assign sysclk_on_hs_crystal_osc = !osc_eff_q;
    assign power_mode = active_mode_q;

    // ==========================================================
    // Timer tick prescaler
    logic [6:0] tick_mask;
    assign tick_mask = 7'((8'h01 << tick_q) - 8'h01);
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tick_cnt_q <= 7'h00;
        end else if (!running || (tick_cnt_q & tick_mask) == tick_mask) begin
            tick_cnt_q <= 7'h00;
        end else begin
            tick_cnt_q <= tick_cnt_q + 7'h01;
        end
    end
    assign timer_tick_en = running && (tick_cnt_q & tick_mask) == tick_mask;

    // ==========================================================
    // Read data
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                pmc_pkg::ADDR_POWER_MODE_COMMAND: sfr_rdata <= {cmd_spare_q, 2'b00};
                pmc_pkg::ADDR_SLEEP_CTRL: sfr_rdata <= {1'b0, osc_ready.hs_crystal_osc_ok && hs_crystal_osc_running,
                    osc_ready.hfrc_ok && pwr_ctrl.hfrc_on, pmc_pkg::RST_CAUSE_POR, unused_osc_powerdown_q, mode_q};
                pmc_pkg::ADDR_CLOCK_CONTROL_REG: sfr_rdata <= {lowfreq_source_select_q, osc_sel_q, tick_q, rsvd_q, spd_q};
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule : pmc_power_mode_ctrl

/* dv/pmc_power_mode_ctrl_checker.sv */
`timescale 1ns/10ps
module pmc_power_mode_ctrl_checker (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire pmc_pkg::pmc_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic port_irq,
    input wire logic sleep_timer_evt,
    input wire logic por_event,
    input wire pmc_pkg::pmc_ready_t osc_ready,
    input wire pmc_pkg::pmc_pwr_ctrl_t pwr_ctrl,
    input wire logic sysclk_on_hs_crystal_osc,
    input wire logic timer_tick_en,
    input wire logic [1:0] power_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ==========================================
    // Mode entry steps
    sequence s_mode_wr;
        sfr_req.wr && sfr_req.addr == 8'hbe && sfr_req.wdata[1:0] != 2'h0;
    endsequence
    sequence s_cmd_wr;
        sfr_req.wr && sfr_req.addr == 8'h87 && sfr_req.wdata[0];
    endsequence
    // ==========================================
    // Properties
    a_mode_entered: assert property (s_mode_wr ##2 s_cmd_wr |=> power_mode == $past(sfr_req.wdata[1:0], 3))
        else $error("mode not entered");
    a_cmd_reads_zero: assert property (sfr_req.rd && sfr_req.addr == 8'h87 |=> sfr_rdata[1:0] == 2'h0)
        else $error("command bit read nonzero");
    a_unmapped_zero: assert property (sfr_req.rd && !(sfr_req.addr inside {8'h87, 8'hbe, 8'hc6})
        |=> sfr_rdata == 8'h00) else $error("unmapped read nonzero");
    a_full_run_on: assert property (power_mode == pmc_pkg::MODE_FULL_RUN
        |-> pwr_ctrl.dig_reg_on && pwr_ctrl.core_clk_on && pwr_ctrl.periph_on) else $error("run not powered");
    a_short_reg_on: assert property (power_mode == pmc_pkg::MODE_SHORT_SLEEP
        |-> pwr_ctrl.dig_reg_on && pwr_ctrl.lf_osc_on) else $error("short sleep lost regulator");
    a_reg_off_hold: assert property (!pwr_ctrl.dig_reg_on
        |-> pwr_ctrl.io_hold && !pwr_ctrl.hs_crystal_osc_on && !pwr_ctrl.hfrc_on) else $error("deep sleep state wrong");
    a_deep_lf_off: assert property (power_mode == pmc_pkg::MODE_DEEPEST_SLEEP && !pwr_ctrl.dig_reg_on
        |-> !pwr_ctrl.lf_osc_on) else $error("low frequency osc on");
    a_deep_no_timer: assert property (power_mode == 2'h3 && !pwr_ctrl.dig_reg_on && sleep_timer_evt
        && !port_irq && !por_event |=> !pwr_ctrl.dig_reg_on) else $error("timer woke deepest sleep");
    a_wake_bounded: assert property (!pwr_ctrl.dig_reg_on && (port_irq || por_event
        || (sleep_timer_evt && power_mode != 2'h3)) |-> ##[1:40] power_mode == 2'h0) else $error("no wake");
    a_release_ready: assert property ($rose(pwr_ctrl.core_clk_on)
        |-> osc_ready.dig_reg_ok && osc_ready.hfrc_ok) else $error("released before ready");
    a_hs_crystal_osc_switch: assert property ($rose(sysclk_on_hs_crystal_osc) |-> $past(osc_ready.hs_crystal_osc_ok))
        else $error("crystal used before stable");
endmodule : pmc_power_mode_ctrl_checker

/* dv/power_mode_clock_manager_test.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module power_mode_clock_manager_test;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    pmc_pkg::pmc_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic port_irq = 1'b0;
    logic sleep_timer_evt = 1'b0;
    logic por_event = 1'b0;
    pmc_pkg::pmc_ready_t osc_ready = '0;
    pmc_pkg::pmc_pwr_ctrl_t pwr_ctrl;
    logic sysclk_on_hs_crystal_osc;
    logic timer_tick_en;
    logic [1:0] power_mode;
    int mismatches = 0;
    int checks = 0;
    int seed = 32'h1570;
    int gap;
    int n;
    logic [7:0] rd;
    logic [7:0] d;
    logic [7:0] clk_m;
    logic [2:0] r;

    always #2 clk_sys = ~clk_sys;
    // Analog ready levels follow their enables one cycle late
    always @(posedge clk_sys) osc_ready <= #1 {pwr_ctrl.dig_reg_on, pwr_ctrl.hs_crystal_osc_on, pwr_ctrl.hfrc_on};

    pmc_power_mode_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .port_irq(port_irq), .sleep_timer_evt(sleep_timer_evt), .por_event(por_event), .osc_ready(osc_ready),
        .pwr_ctrl(pwr_ctrl), .sysclk_on_hs_crystal_osc(sysclk_on_hs_crystal_osc), .timer_tick_en(timer_tick_en),
        .power_mode(power_mode));

    // ==========================================
    // Tasks
    task automatic cycles(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : cycles
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] v);
        cycles(1);
        sfr_req = '{wr: w, rd: !w, addr: a, wdata: v};
        cycles(1);
        sfr_req = '0;
        rd = sfr_rdata;
    endtask : sfr
    task automatic reset_dut;
        nrst = 1'b0;
        cycles(10);
        nrst = 1'b1;
        clk_m = 8'hc9;
    endtask : reset_dut
    task automatic tick_gap(output int g);
        for (g = 0; g < 300 && timer_tick_en !== 1'b1; g++) cycles(1);
        cycles(1);
        for (g = 1; g < 300 && timer_tick_en !== 1'b1; g++) cycles(1);
    endtask : tick_gap
    task automatic finish_test;
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        mismatches++;
        finish_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        reset_dut();
        `CHK(pwr_ctrl.lf_hs_crystal_osc_sel, 1'b0)
        tick_gap(gap);
        `CHK(gap, 2)
        sfr(0, 8'hc6, 8'h00);
        `CHK(rd, 8'hc9)
        sfr(0, 8'hbe, 8'h00);
        `CHK(rd & 8'hdf, 8'h04)
        `CHK(pwr_ctrl.hs_crystal_osc_on, 1'b0)
        d = 8'($random(seed));
        sfr(1, 8'h87, d | 8'h01);
        sfr(0, 8'h87, 8'h00);
        `CHK(rd, d & 8'hfc)
        `CHK(power_mode, pmc_pkg::MODE_FULL_RUN)
        sfr(1, 8'h55, d);
        sfr(0, 8'h55, 8'h00);
        `CHK(rd, 8'h00)
        r = 3'($random(seed));
        for (int i = 0; i < 8; i++) begin
            clk_m = {2'b11, 3'(i) ^ r, 3'b001};
            sfr(1, 8'hc6, clk_m);
            sfr(0, 8'hc6, 8'h00);
            `CHK(rd, clk_m)
            tick_gap(gap);
            `CHK(gap, 1 << clk_m[5:3])
        end
        // Source and speed bits change together
        sfr(1, 8'hc6, clk_m & 8'hbe);
        for (n = 0; n < 40 && sysclk_on_hs_crystal_osc !== 1'b1; n++) cycles(1);
        `CHK(sysclk_on_hs_crystal_osc, 1'b1)
        sfr(0, 8'hbe, 8'h00);
        `CHK(rd[6], 1'b1)
        `CHK(rd[2], 1'b0)
        sfr(1, 8'hc6, clk_m);
        for (n = 0; n < 40 && sysclk_on_hs_crystal_osc !== 1'b0; n++) cycles(1);
        `CHK(sysclk_on_hs_crystal_osc, 1'b0)
        for (int m = 1; m < 4; m++) begin
            sfr(1, 8'hbe, 8'h04 | 8'(m));
            sfr(1, 8'h87, 8'h01);
            `CHK(power_mode, 2'(m))
            sfr(0, 8'h87, 8'h00);
            `CHK(rd[0], 1'b0)
            `CHK(pwr_ctrl.periph_on, 1'(m != 1))
            cycles(40);
            `CHK(pwr_ctrl.core_clk_on, 1'b0)
            `CHK(pwr_ctrl.dig_reg_on, 1'(m == 1))
            `CHK(pwr_ctrl.hfrc_on | pwr_ctrl.hs_crystal_osc_on, 1'b0)
            `CHK(pwr_ctrl.lf_osc_on, 1'(m != 3))
            if (m > 1) begin
                `CHK(pwr_ctrl.io_hold, 1'b1)
                `CHK(pwr_ctrl.retained_on, 1'b1)
                `CHK(pwr_ctrl.volatile_ram_on | pwr_ctrl.radio_buf_on, 1'b0)
            end
            if (m == 3) begin
                sleep_timer_evt = 1'b1;
                cycles(1);
                sleep_timer_evt = 1'b0;
                cycles(5);
                `CHK(power_mode, 2'h3)
            end
            {por_event, sleep_timer_evt, port_irq} = 3'b001 << (m - 1);
            cycles(1);
            {por_event, sleep_timer_evt, port_irq} = 3'b000;
            for (n = 0; n < 60 && power_mode !== 2'h0; n++) cycles(1);
            `CHK(power_mode, 2'h0)
            `CHK(pwr_ctrl.core_clk_on, 1'b1)
            `CHK(sysclk_on_hs_crystal_osc, 1'b0)
            `CHK(pwr_ctrl.hs_crystal_osc_on, 1'b0)
            sfr(0, 8'hbe, 8'h00);
            `CHK(rd[1:0], 2'h0)
            `CHK(rd[2], 1'b1)
        end
        // Crystal selected across a short sleep
        sfr(1, 8'hc6, clk_m & 8'hbe);
        for (n = 0; n < 40 && sysclk_on_hs_crystal_osc !== 1'b1; n++) cycles(1);
        sfr(1, 8'hc6, clk_m & 8'h3e);
        sfr(0, 8'hc6, 8'h00);
        `CHK(rd, clk_m & 8'hbe)
        sfr(1, 8'hbe, 8'h01);
        sfr(1, 8'h87, 8'h01);
        cycles(10);
        port_irq = 1'b1;
        cycles(1);
        port_irq = 1'b0;
        for (n = 0; n < 60 && power_mode !== 2'h0; n++) cycles(1);
        `CHK(power_mode, 2'h0)
        `CHK(sysclk_on_hs_crystal_osc, 1'b0)
        `CHK(pwr_ctrl.hfrc_on, 1'b1)
        for (n = 0; n < 40 && sysclk_on_hs_crystal_osc !== 1'b1; n++) cycles(1);
        `CHK(sysclk_on_hs_crystal_osc, 1'b1)
        sfr(1, 8'hbe, 8'h06);
        sfr(1, 8'h87, 8'h01);
        cycles(40);
        reset_dut();
        `CHK(power_mode, 2'h0)
        `CHK(pwr_ctrl.core_clk_on, 1'b1)
        sfr(0, 8'hc6, 8'h00);
        `CHK(rd, 8'hc9)
        // Low-frequency source changed while on the RC
        sfr(1, 8'hc6, 8'h49);
        sfr(0, 8'hc6, 8'h00);
        `CHK(rd, 8'h49)
        `CHK(pwr_ctrl.lf_hs_crystal_osc_sel, 1'b1)
        finish_test();
    end
endmodule : power_mode_clock_manager_test

bind pmc_power_mode_ctrl pmc_power_mode_ctrl_checker i_chk (.clk_sys(clk_sys), .nrst(nrst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .port_irq(port_irq), .sleep_timer_evt(sleep_timer_evt), .por_event(por_event),
    .osc_ready(osc_ready), .pwr_ctrl(pwr_ctrl), .sysclk_on_hs_crystal_osc(sysclk_on_hs_crystal_osc),
    .timer_tick_en(timer_tick_en), .power_mode(power_mode));
